//--- core/arc_defs.vh
// Constants for the converter reference, clock and analog-pin configuration block
`ifndef ARC_DEFS_VH
`define ARC_DEFS_VH
// Register byte addresses (APB, one word each)
`define ARC_ADDR_CONFIG_TWO   12'h000
`define ARC_ADDR_PIN_SELECT   12'h004
// Field positions in adc_config_two
`define ARC_BIT_CHAN_SEL      7
`define ARC_BIT_BG_EN         6
`define ARC_BIT_REF_SEL       4
`define ARC_DIV_HI            2
`define ARC_DIV_LO            0
// Writable bit mask: bits 5 and 3 unimplemented
`define ARC_CFG_MASK          8'hd7
// Reset values
`define ARC_CFG_RESET         8'h00
`define ARC_PIN_RESET         8'hff
// Highest legal divider code
`define ARC_DIV_MAX_CODE      3'h6
`endif

//--- core/arc_config.v
// Converter reference, clock divider and analog-pin configuration with APB slave
`timescale 1ns/1ps
`include "arc_defs.vh"

// Function
// RULE1: A one in the bandgap enable bit powers the bandgap circuit, a zero turns it off.
// RULE2: Bits 5 and 3 of the second control register read as zero and ignore writes.
// RULE3: A one in the reference select bit takes the reference from the external reference pin.
// RULE4: A zero in the reference select bit takes the reference from the positive supply.
// RULE5: While the external reference is selected, all other functions on that pin are disabled.
// RULE6: Divider codes 000 to 110 give the system clock divided by 1, 2, 4, 8, 16, 32 or 64. Code 000 holds conv_clk_out high instead of passing the clock.
// RULE7: Software must not program divider code 111.
// RULE8: Analog-pin enable bit n set to one makes its pin analog channel n.
// RULE9: Analog-pin enable bit n cleared returns its pin to the digital or shared function.
// RULE10: Software enables the bandgap before selecting it, which disconnects all external channels.
// RULE11: An analog-selected pin loses its digital function and its pull-high resistor.
// RULE12: Implemented bits read back as written and take effect on the clock edge after the write.
module arc_config (
   // Clock and reset
   input  wire        sys_clk_in,
   input  wire        rst_b_in,
   // APB slave
   input  wire        psel_in,
   input  wire        penable_in,
   input  wire        pwrite_in,
   input  wire [11:0] paddr_in,
   input  wire [31:0] pwdata_in,
   input  wire [3:0]  pstrb_in,
   output reg  [31:0] prdata_out,
   output wire        pready_out,
   output wire        pslverr_out,
   // Converter controls
   output reg         bandgap_enable_out,
   output reg         bandgap_channel_select_out,
   output reg         ref_ext_select_out,
   output reg         ref_vdd_select_out,
   output reg         ref_pin_shared_disable_out,
   output reg         conv_clk_out,
   output reg  [7:0]  analog_channel_connect_out,
   // Port pin controls
   output reg  [7:0]  analog_pin_enable_out,
   output reg  [7:0]  digital_func_enable_out,
   output reg  [7:0]  pullhigh_allow_out
);

   // Register state
   reg  [7:0]  cfg_r;
   reg  [7:0]  cfg_nxt;
   reg  [7:0]  pin_r;
   reg  [7:0]  pin_nxt;
   reg  [5:0]  div_cnt_r;
   reg  [5:0]  div_cnt_nxt;
   reg  [31:0] rdata_nxt;
   reg         div_tick;

   // Bus decode
   wire        setup_phase;
   wire        access_phase;
   wire        hit_cfg;
   wire        hit_pin;
   wire        hit_any;
   wire        wr_en;
   wire        wr_cfg;
   wire        wr_pin;

   // Per-pin control slices
   wire [7:0]  pin_analog;
   wire [7:0]  pin_digital;
   wire [7:0]  pin_pullhigh;
   wire [7:0]  pin_connect;

   genvar      g;

   // Register select, shared by the write path, the read path and the error flag
   function addr_match(input [11:0] addr, input [11:0] reg_addr);
      addr_match = (addr == reg_addr);
   endfunction

   // Counter tap per divider code; code 111 parks the clock low rather than guessing a rate
   function div_tap(input [2:0] code, input [5:0] cnt);
      case (code)
         3'h0:    div_tap = 1'b1;
         3'h1:    div_tap = cnt[0];
         3'h2:    div_tap = cnt[1];
         3'h3:    div_tap = cnt[2];
         3'h4:    div_tap = cnt[3];
         3'h5:    div_tap = cnt[4];
         3'h6:    div_tap = cnt[5];
         default: div_tap = 1'b0;
      endcase
   endfunction

   // Bus phases and address hits
   assign setup_phase  = psel_in & ~penable_in;
   assign access_phase = psel_in & penable_in;
   assign hit_cfg      = addr_match(paddr_in, `ARC_ADDR_CONFIG_TWO);
   assign hit_pin      = addr_match(paddr_in, `ARC_ADDR_PIN_SELECT);
   assign hit_any      = hit_cfg | hit_pin;

   // Zero-wait slave; unmapped addresses answer with an error and change nothing
   assign pready_out   = 1'b1;
   assign pslverr_out  = access_phase & ~hit_any;

   // Only byte lane 0 holds register bits, so only its strobe gates a write
   assign wr_en        = access_phase & pwrite_in & pstrb_in[0];
   assign wr_cfg       = wr_en & hit_cfg;
   assign wr_pin       = wr_en & hit_pin;

   always @* begin
      cfg_nxt = cfg_r;
      if (wr_cfg) begin
         cfg_nxt = pwdata_in[7:0] & `ARC_CFG_MASK;  // see RULE2
      end
   end

   always @* begin
      pin_nxt = pin_r;
      if (wr_pin) begin
         pin_nxt = pwdata_in[7:0];  // see RULE8
      end
   end

   always @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cfg_r <= `ARC_CFG_RESET;
         pin_r <= `ARC_PIN_RESET;
      end else begin
         cfg_r <= cfg_nxt;  // see RULE12
         pin_r <= pin_nxt;  // see RULE12
      end
   end

   // Read data captured in the setup cycle, so it stands from a flop through the access cycle;
   // a write lands no later than the edge that opens the next setup cycle, so a read never misses it
   always @* begin
      rdata_nxt = prdata_out;
      if (setup_phase & ~pwrite_in) begin
         rdata_nxt = 32'h0000_0000;
         if (hit_cfg) begin
            rdata_nxt = {24'h00_0000, cfg_r & `ARC_CFG_MASK};  // see RULE2
         end else if (hit_pin) begin
            rdata_nxt = {24'h00_0000, pin_r};  // see RULE12
         end
      end
   end

   always @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         prdata_out <= 32'h0000_0000;
      end else begin
         prdata_out <= rdata_nxt;
      end
   end

   // Free-running divider; wraps every 64 cycles, the longest period on offer
   always @* begin
      div_cnt_nxt = div_cnt_r + 6'h01;
   end

   always @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         div_cnt_r <= 6'h00;
      end else begin
         div_cnt_r <= div_cnt_nxt;
      end
   end

   always @* begin
      div_tick = div_tap(cfg_r[`ARC_DIV_HI:`ARC_DIV_LO], div_cnt_r);  // see RULE6
   end

   generate
      for (g = 0; g < 8; g = g + 1) begin : g_pin
         // Analog use strips the digital path and its pull-high
         assign pin_analog[g]   = pin_r[g];  // see RULE8
         assign pin_digital[g]  = ~pin_r[g];  // see RULE9 see RULE11
         assign pin_pullhigh[g] = ~pin_r[g];  // see RULE11
         // Bandgap selection isolates every external channel
         assign pin_connect[g]  = pin_r[g] & ~cfg_r[`ARC_BIT_CHAN_SEL];  // see RULE10
      end
   endgenerate

   // Code 000 is a clock-rate enable level rather than a true clock
   always @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         conv_clk_out <= 1'b0;
      end else begin
         conv_clk_out <= div_tick;  // see RULE6
      end
   end

   // Bandgap and reference controls follow the register one cycle later
   always @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         bandgap_enable_out         <= 1'b0;
         bandgap_channel_select_out <= 1'b0;
         ref_ext_select_out         <= 1'b0;
         ref_vdd_select_out         <= 1'b1;
         ref_pin_shared_disable_out <= 1'b0;
      end else begin
         bandgap_enable_out         <= cfg_r[`ARC_BIT_BG_EN];  // see RULE1
         bandgap_channel_select_out <= cfg_r[`ARC_BIT_CHAN_SEL];
         ref_ext_select_out         <= cfg_r[`ARC_BIT_REF_SEL];  // see RULE3
         ref_vdd_select_out         <= ~cfg_r[`ARC_BIT_REF_SEL];  // see RULE4
         ref_pin_shared_disable_out <= cfg_r[`ARC_BIT_REF_SEL];  // see RULE5
      end
   end

   // Pin controls reset to the register's all-analog state, so no pull-high loads an analog pin
   always @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         analog_pin_enable_out      <= `ARC_PIN_RESET;
         analog_channel_connect_out <= `ARC_PIN_RESET;
         digital_func_enable_out    <= ~`ARC_PIN_RESET;
         pullhigh_allow_out         <= ~`ARC_PIN_RESET;
      end else begin
         analog_pin_enable_out      <= pin_analog;  // see RULE8
         analog_channel_connect_out <= pin_connect;  // see RULE10
         digital_func_enable_out    <= pin_digital;  // see RULE9
         pullhigh_allow_out         <= pin_pullhigh;  // see RULE11
      end
   end

endmodule // arc_config

//--- dv/arc_config_properties.sv
// Checker for the converter configuration block
`timescale 1ns/1ps
module arc_chk(
   input logic sys_clk_in, rst_b_in, psel_in, penable_in, pwrite_in, pslverr_out, conv_clk_out,
   input logic bandgap_enable_out, bandgap_channel_select_out, ref_ext_select_out, ref_vdd_select_out,
   input logic ref_pin_shared_disable_out, input logic [11:0] paddr_in, input logic [3:0] pstrb_in,
   input logic [31:0] pwdata_in, prdata_out, input logic [7:0] analog_channel_connect_out,
   input logic [7:0] analog_pin_enable_out, digital_func_enable_out, pullhigh_allow_out);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rst_b_in);
   logic [2:0] code_r;
   wire wr = psel_in && penable_in && pwrite_in && pstrb_in[0];
   // Shadow of the divider code, seen only through bus writes
   always_ff @(posedge sys_clk_in or negedge rst_b_in)
      if (!rst_b_in) code_r <= 3'h0;
      else if (wr && paddr_in == 12'h000) code_r <= pwdata_in[2:0];
   a_bg_follow: assert property (wr && paddr_in == 12'h000 |-> ##2 bandgap_enable_out == $past(pwdata_in[6], 2))
      else $error("bandgap enable wrong");
   a_pin_follow: assert property (wr && paddr_in == 12'h004 |-> ##2 analog_pin_enable_out == $past(pwdata_in[7:0], 2))
      else $error("pin enable wrong");
   a_pins_digital: assert property (digital_func_enable_out == ~analog_pin_enable_out && pullhigh_allow_out == ~analog_pin_enable_out)
      else $error("digital function wrong");
   a_ref_pair: assert property (ref_vdd_select_out == !ref_ext_select_out && ref_pin_shared_disable_out == ref_ext_select_out)
      else $error("reference select wrong");
   a_chan_gate: assert property (analog_channel_connect_out == (bandgap_channel_select_out ? 8'h00 : analog_pin_enable_out))
      else $error("channel connect wrong");
   a_rsvd_zero: assert property (psel_in && penable_in && !pwrite_in && paddr_in == 12'h000 |-> (prdata_out & 32'hffffff28) == 0)
      else $error("reserved bits set");
   a_unmapped_err: assert property (psel_in && penable_in |-> pslverr_out == !(paddr_in == 12'h000 || paddr_in == 12'h004))
      else $error("slave error wrong");
   a_div_bypass: assert property (code_r == 3'h0 [*3] |-> conv_clk_out)
      else $error("undivided clock wrong");
   a_div_two: assert property (code_r == 3'h1 [*3] |-> conv_clk_out != $past(conv_clk_out))
      else $error("half clock wrong");
   c_cfg_write: cover property (wr && paddr_in == 12'h000);
   c_unmapped: cover property (pslverr_out);
   c_bg_chan: cover property (bandgap_channel_select_out && analog_pin_enable_out != 8'h00);
endmodule // arc_chk
bind arc_config arc_chk u_chk(.*);

//--- dv/tb.sv
// Testbench for the converter configuration block
`timescale 1ns/1ps
module tb;
   logic sys_clk_in = 0, rst_b_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0, err, v;
   logic [11:0] paddr_in = 0;
   logic [31:0] pwdata_in = 0, rd, n;
   logic [3:0]  pstrb_in = 0;
   logic [7:0]  rnd = 8'h61, c, p, q = 0;
   int          num_errors = 0, checked = 0, cyc = 0;
   wire [31:0]  prdata_out;
   wire pready_out, pslverr_out, bandgap_enable_out, bandgap_channel_select_out, ref_ext_select_out;
   wire ref_vdd_select_out, ref_pin_shared_disable_out, conv_clk_out;
   wire [7:0] analog_channel_connect_out, analog_pin_enable_out, digital_func_enable_out, pullhigh_allow_out;
   arc_config dut(.*);
   always #25 sys_clk_in = ~sys_clk_in;
   function automatic logic [7:0] lfsr(logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task complete_run;
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task chk(logic [31:0] got, exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One idle cycle first, so a release never meets a new request in one step
   task apb(logic w, logic [11:0] a, logic [31:0] d);
      @(posedge sys_clk_in);
      {psel_in, pwrite_in, paddr_in, pwdata_in, pstrb_in} <= {1'b1, w, a, d, 3'h0, w};
      @(posedge sys_clk_in) penable_in <= 1;
      do @(posedge sys_clk_in); while (pready_out !== 1'b1);
      {rd, err} = {prdata_out, pslverr_out};
      {psel_in, penable_in} <= 2'b00;
   endtask
   always @(posedge sys_clk_in) if (++cyc > 3000) begin
      num_errors++;
      $display("mismatch %0t timeout", $time);
      complete_run();
   end
   initial begin
      repeat (4) @(posedge sys_clk_in);
      rst_b_in <= 1;
      apb(0, 12'h000, 0);
      chk(rd, 0);
      apb(0, 12'h004, 0);
      chk(rd, 32'hff);
      chk({analog_pin_enable_out, pullhigh_allow_out, ref_vdd_select_out}, {8'hff, 8'h00, 1'b1});
      $display("test reset done");
      repeat (12) begin
         rnd = lfsr(rnd);
         c = {rnd[7:3], rnd[2:0] % 3'h7};
         c[7] = c[7] & c[6] & q[6];
         q = c;
         apb(1, 12'h000, c);
         rnd = lfsr(rnd);
         p = rnd;
         apb(1, 12'h004, p);
         apb(1, 12'h008, 32'h5a);
         chk(err, 1);
         apb(0, 12'h000, 0);
         chk(rd, c & 8'hd7);
         apb(0, 12'h004, 0);
         chk(rd, p);
         chk({bandgap_enable_out, ref_ext_select_out, analog_channel_connect_out}, {c[6], c[4], c[7] ? 8'h00 : p});
         chk({ref_vdd_select_out, ref_pin_shared_disable_out, bandgap_channel_select_out}, {~c[4], c[4], c[7]});
         chk({analog_pin_enable_out, digital_func_enable_out, pullhigh_allow_out}, {p, ~p, ~p});
      end
      $display("test registers done");
      for (int k = 0; k < 7; k++) begin
         apb(1, 12'h000, k);
         repeat (3) @(posedge sys_clk_in);
         {n, v} = {32'h0, conv_clk_out};
         repeat (128) begin
            @(posedge sys_clk_in);
            n += conv_clk_out ^ v;
            v = conv_clk_out;
         end
         chk(n, k ? 256 >> k : 0);
         if (k == 0) chk(v, 1);
      end
      $display("test divider done");
      complete_run();
   end
endmodule // tb
